/* hdl/thermal_failsafe_pkg.sv */
package thermal_failsafe_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REMOTE1_CRITICAL_LIMIT_ADDR = 8'h6A;
  localparam logic [7:0] LOCAL_CRITICAL_LIMIT_ADDR = 8'h6B;
  localparam logic [7:0] REMOTE2_CRITICAL_LIMIT_ADDR = 8'h6C;
  localparam logic [7:0] REMOTE1_LOCAL_HYSTERESIS_ADDR = 8'h6D;
  localparam logic [7:0] REMOTE2_HYSTERESIS_ADDR = 8'h6E;
  localparam logic [7:0] TEST_TREE_ENABLE_ADDR = 8'h6F;
  localparam logic [7:0] REMOTE1_TEMP_OFFSET_ADDR = 8'h70;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CRITICAL_LIMIT_RESET = 8'hA4;
  localparam logic [7:0] REMOTE1_LOCAL_HYSTERESIS_RESET = 8'h44;
  localparam logic [7:0] REMOTE2_HYSTERESIS_RESET = 8'h40;
  localparam logic [7:0] TEST_TREE_ENABLE_RESET = 8'h00;
  localparam logic [7:0] REMOTE1_TEMP_OFFSET_RESET = 8'h00;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int LOCAL_HYST_FIELD_LSB = 0;
  localparam int REMOTE1_HYST_FIELD_LSB = 4;
  localparam int REMOTE2_HYST_FIELD_LSB = 4;
  localparam int HYST_FIELD_WIDTH = 4;
  localparam int TEST_TREE_ON_BIT = 0;
  localparam logic [7:0] CRITICAL_DISABLE_CODE = 8'h80;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // channel order: 0 remote 1, 1 local, 2 remote 2
  localparam int NUM_CHANNELS = 3;
  localparam int CH_REMOTE1 = 0;
  localparam int CH_LOCAL = 1;
  localparam int CH_REMOTE2 = 2;

  // temperature: 8-bit limit code plus 2 bits of 0.25 degree
  localparam int TEMP_FRAC_BITS = 2;
  localparam int TEMP_WIDTH = 10;

  typedef struct packed {
    logic valid;
    logic [TEMP_WIDTH-1:0] value;
  } temp_result_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

endpackage

/* hdl/thermal_failsafe_limit_regs.sv */
// Behaviour
// - Any channel above its critical limit forces every fan duty to full.
// - A critical limit of 0x80 disables the full-duty override of a channel.
// - Full duty holds until the channel falls below limit minus hysteresis.
// - With the alarm pin as output, exceeding a limit by 0.25 drives it low.
// - Hysteresis is 4 bits per channel: local 3:0, remote 1 7:4, remote 2 7:4.
// - Below its start temperature a fan keeps minimum duty down to start-hyst.
// - Test enable bit 0 enters test-tree mode; clearing it leaves that mode.
// - The signed half-degree remote 1 offset is added to each remote 1 read.
// - With the lock bit set these registers ignore all writes.
// - Above its start temperature a fan runs from minimum duty upward.

// ---------------------------------------------------------------
// per-channel limit and start-temperature evaluation
// ---------------------------------------------------------------
module thermal_channel_eval
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // corrected result
  input wire thermal_failsafe_pkg::temp_result_t i_result,
  // settings
  input wire logic [7:0] i_limit,
  input wire logic [3:0] i_hyst,
  input wire logic [7:0] i_fan_start_temperature,
  // flags
  output logic o_override,
  output logic o_alarm,
  output logic o_fan_running
);

  wire logic [7:0] temp_int;
  wire logic [9:0] limit_q;
  wire logic [8:0] release_diff;
  wire logic [8:0] start_diff;
  wire logic [7:0] release_level;
  wire logic [7:0] start_off_level;
  wire logic disabled;
  wire logic above_limit;
  wire logic above_limit_q;
  wire logic below_release;
  wire logic above_start;
  wire logic at_start_off;

  assign temp_int = i_result.value[9:2];
  assign limit_q = {i_limit, 2'h0};
  assign release_diff = {1'b0, i_limit} - {5'h00, i_hyst};
  assign start_diff = {1'b0, i_fan_start_temperature} - {5'h00, i_hyst};
  assign release_level = release_diff[8] ? 8'h00 : release_diff[7:0];
  assign start_off_level = start_diff[8] ? 8'h00 : start_diff[7:0];
  assign disabled = (i_limit == thermal_failsafe_pkg::CRITICAL_DISABLE_CODE);
  assign above_limit = (temp_int > i_limit);
  assign above_limit_q = (i_result.value > limit_q);
  assign below_release = (temp_int < release_level);
  assign above_start = (temp_int > i_fan_start_temperature);
  assign at_start_off = (temp_int <= start_off_level);

  // full-duty override latch
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_override <= 1'b0;
    else if (disabled)
      o_override <= 1'b0;
    else if (i_result.valid)
    begin
      if (above_limit)
        o_override <= 1'b1;
      else if (below_release)
        o_override <= 1'b0;
    end
  end

  // alarm latch, quarter-degree resolution
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_alarm <= 1'b0;
    else if (disabled)
      o_alarm <= 1'b0;
    else if (i_result.valid)
    begin
      if (above_limit_q)
        o_alarm <= 1'b1;
      else if (below_release)
        o_alarm <= 1'b0;
    end
  end

  // minimum-duty run latch
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_fan_running <= 1'b0;
    else if (i_result.valid)
    begin
      if (above_start)
        o_fan_running <= 1'b1;
      else if (at_start_off)
        o_fan_running <= 1'b0;
    end
  end

endmodule

// ---------------------------------------------------------------
// register bank, offset correction and fan override
// ---------------------------------------------------------------
module thermal_failsafe_limit_regs
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // register port from the serial bus engine
  input wire thermal_failsafe_pkg::reg_access_t i_reg,
  output logic [7:0] o_reg_rdata,
  // configuration from outside this block
  input wire logic i_config_lock,
  input wire logic i_alarm_pin_is_output,
  // raw temperature results
  input wire thermal_failsafe_pkg::temp_result_t i_remote1_raw,
  input wire thermal_failsafe_pkg::temp_result_t i_local_result,
  input wire thermal_failsafe_pkg::temp_result_t i_remote2_result,
  // fan start temperatures, one per channel
  input wire logic [2:0][7:0] i_fan_start_temperature,
  // duty requested by the automatic fan loop
  input wire logic [2:0][7:0] i_loop_duty,
  // fan drive
  output logic [2:0][7:0] o_fan_duty,
  output logic [2:0] o_fan_running,
  output logic o_full_duty_override,
  // corrected remote 1 result
  output thermal_failsafe_pkg::temp_result_t o_remote1_result,
  // thermal alarm pin
  input wire logic i_thermal_alarm_pin,
  output logic o_thermal_alarm_pin,
  output logic o_thermal_alarm_pin_oe,
  // test mode
  output logic o_test_tree_on
);

  logic [2:0][7:0] critical_limit;
  logic [7:0] remote1_local_hysteresis;
  logic [7:0] remote2_hysteresis;
  logic test_tree_on;
  logic [7:0] remote1_temp_offset;
  thermal_failsafe_pkg::temp_result_t remote1_result;

  wire logic write_ok;
  wire logic [7:0] next_rdata;
  wire logic [11:0] offset_sum;
  wire logic [9:0] corrected;
  wire logic [2:0][3:0] hyst;
  wire thermal_failsafe_pkg::temp_result_t [2:0] results;
  wire logic [2:0] override;
  wire logic [2:0] alarm;
  wire logic [2:0] running;
  wire logic any_override;
  wire logic any_alarm;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  assign write_ok = i_reg.write & ~i_config_lock;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      critical_limit[0] <= thermal_failsafe_pkg::CRITICAL_LIMIT_RESET;
      critical_limit[1] <= thermal_failsafe_pkg::CRITICAL_LIMIT_RESET;
      critical_limit[2] <= thermal_failsafe_pkg::CRITICAL_LIMIT_RESET;
      remote1_local_hysteresis <=
        thermal_failsafe_pkg::REMOTE1_LOCAL_HYSTERESIS_RESET;
      remote2_hysteresis <= thermal_failsafe_pkg::REMOTE2_HYSTERESIS_RESET;
      test_tree_on <= thermal_failsafe_pkg::TEST_TREE_ENABLE_RESET[0];
      remote1_temp_offset <= thermal_failsafe_pkg::REMOTE1_TEMP_OFFSET_RESET;
    end
    else if (write_ok)
    begin
      case (i_reg.addr)
        thermal_failsafe_pkg::REMOTE1_CRITICAL_LIMIT_ADDR:
          critical_limit[0] <= i_reg.wdata;
        thermal_failsafe_pkg::LOCAL_CRITICAL_LIMIT_ADDR:
          critical_limit[1] <= i_reg.wdata;
        thermal_failsafe_pkg::REMOTE2_CRITICAL_LIMIT_ADDR:
          critical_limit[2] <= i_reg.wdata;
        thermal_failsafe_pkg::REMOTE1_LOCAL_HYSTERESIS_ADDR:
          remote1_local_hysteresis <= i_reg.wdata;
        thermal_failsafe_pkg::REMOTE2_HYSTERESIS_ADDR:
          remote2_hysteresis <= i_reg.wdata;
        thermal_failsafe_pkg::TEST_TREE_ENABLE_ADDR:
          // reserved bits are not stored
          test_tree_on <=
            i_reg.wdata[thermal_failsafe_pkg::TEST_TREE_ON_BIT];
        thermal_failsafe_pkg::REMOTE1_TEMP_OFFSET_ADDR:
          remote1_temp_offset <= i_reg.wdata;
        default:
          ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  assign next_rdata =
    (i_reg.addr == thermal_failsafe_pkg::REMOTE1_CRITICAL_LIMIT_ADDR) ?
      critical_limit[0] :
    (i_reg.addr == thermal_failsafe_pkg::LOCAL_CRITICAL_LIMIT_ADDR) ?
      critical_limit[1] :
    (i_reg.addr == thermal_failsafe_pkg::REMOTE2_CRITICAL_LIMIT_ADDR) ?
      critical_limit[2] :
    (i_reg.addr == thermal_failsafe_pkg::REMOTE1_LOCAL_HYSTERESIS_ADDR) ?
      remote1_local_hysteresis :
    (i_reg.addr == thermal_failsafe_pkg::REMOTE2_HYSTERESIS_ADDR) ?
      remote2_hysteresis :
    (i_reg.addr == thermal_failsafe_pkg::TEST_TREE_ENABLE_ADDR) ?
      {7'h00, test_tree_on} :
    (i_reg.addr == thermal_failsafe_pkg::REMOTE1_TEMP_OFFSET_ADDR) ?
      remote1_temp_offset :
      thermal_failsafe_pkg::READ_UNMAPPED;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reg_rdata <= thermal_failsafe_pkg::READ_UNMAPPED;
    else
      o_reg_rdata <= next_rdata;
  end

  // ---------------------------------------------------------------
  // remote 1 offset correction, saturating
  // ---------------------------------------------------------------
  // one offset step is two quarter-degree steps
  assign offset_sum = {2'h0, i_remote1_raw.value} +
    {{3{remote1_temp_offset[7]}}, remote1_temp_offset, 1'b0};
  assign corrected = offset_sum[11] ? 10'h000 :
    (offset_sum[10] ? 10'h3FF : offset_sum[9:0]);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      remote1_result <= '0;
    else
    begin
      remote1_result.valid <= i_remote1_raw.valid;
      if (i_remote1_raw.valid)
        remote1_result.value <= corrected;
    end
  end

  // ---------------------------------------------------------------
  // channel evaluation
  // ---------------------------------------------------------------
  assign hyst[thermal_failsafe_pkg::CH_REMOTE1] =
    remote1_local_hysteresis[thermal_failsafe_pkg::REMOTE1_HYST_FIELD_LSB +:
      thermal_failsafe_pkg::HYST_FIELD_WIDTH];
  assign hyst[thermal_failsafe_pkg::CH_LOCAL] =
    remote1_local_hysteresis[thermal_failsafe_pkg::LOCAL_HYST_FIELD_LSB +:
      thermal_failsafe_pkg::HYST_FIELD_WIDTH];
  assign hyst[thermal_failsafe_pkg::CH_REMOTE2] =
    remote2_hysteresis[thermal_failsafe_pkg::REMOTE2_HYST_FIELD_LSB +:
      thermal_failsafe_pkg::HYST_FIELD_WIDTH];

  assign results[thermal_failsafe_pkg::CH_REMOTE1] = remote1_result;
  assign results[thermal_failsafe_pkg::CH_LOCAL] = i_local_result;
  assign results[thermal_failsafe_pkg::CH_REMOTE2] = i_remote2_result;

  genvar ch;
  generate
    for (ch = 0; ch < thermal_failsafe_pkg::NUM_CHANNELS; ch++)
    begin : g_channel
      thermal_channel_eval u_eval
      (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_result(results[ch]),
        .i_limit(critical_limit[ch]),
        .i_hyst(hyst[ch]),
        .i_fan_start_temperature(i_fan_start_temperature[ch]),
        .o_override(override[ch]),
        .o_alarm(alarm[ch]),
        .o_fan_running(running[ch])
      );
    end
  endgenerate

  assign any_override = |override;
  assign any_alarm = (|alarm) & i_alarm_pin_is_output;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_fan_duty <= '0;
      o_fan_running <= 3'h0;
      o_full_duty_override <= 1'b0;
      o_remote1_result <= '0;
      o_thermal_alarm_pin <= 1'b1;
      o_thermal_alarm_pin_oe <= 1'b0;
      o_test_tree_on <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < thermal_failsafe_pkg::NUM_CHANNELS; i++)
      begin
        o_fan_duty[i] <= any_override ?
          thermal_failsafe_pkg::FULL_DUTY : i_loop_duty[i];
      end
      o_fan_running <= running;
      o_full_duty_override <= any_override;
      o_remote1_result <= remote1_result;
      // open-drain style: drive low only while alarmed
      o_thermal_alarm_pin <= 1'b0;
      o_thermal_alarm_pin_oe <= any_alarm;
      o_test_tree_on <= test_tree_on;
    end
  end

  // pin level is read by the fan loop elsewhere; not used here
  wire logic unused_alarm_in;
  assign unused_alarm_in = i_thermal_alarm_pin;

endmodule

/* dv/thermal_failsafe_checker.sv */
module thermal_failsafe_checker
(
  // watched ports
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire thermal_failsafe_pkg::reg_access_t i_reg,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_config_lock,
  input wire logic i_alarm_pin_is_output,
  input wire thermal_failsafe_pkg::temp_result_t i_remote1_raw,
  input wire thermal_failsafe_pkg::temp_result_t i_local_result,
  input wire thermal_failsafe_pkg::temp_result_t i_remote2_result,
  input wire logic [2:0][7:0] i_fan_start_temperature,
  input wire logic [2:0][7:0] i_loop_duty,
  input wire logic [2:0][7:0] o_fan_duty,
  input wire logic [2:0] o_fan_running,
  input wire logic o_full_duty_override,
  input wire thermal_failsafe_pkg::temp_result_t o_remote1_result,
  input wire logic i_thermal_alarm_pin,
  input wire logic o_thermal_alarm_pin,
  input wire logic o_thermal_alarm_pin_oe,
  input wire logic o_test_tree_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic new_result = i_local_result.valid | i_remote2_result.valid;
  // accepted write of the disable code into one of the three limits
  wire logic limit_off_wr = i_reg.write && !i_config_lock &&
    i_reg.wdata == thermal_failsafe_pkg::CRITICAL_DISABLE_CODE &&
    i_reg.addr >= thermal_failsafe_pkg::REMOTE1_CRITICAL_LIMIT_ADDR &&
    i_reg.addr <= thermal_failsafe_pkg::REMOTE2_CRITICAL_LIMIT_ADDR;
  sequence s_test_on;
    i_reg.write && !i_config_lock && i_reg.wdata[0] &&
      i_reg.addr == thermal_failsafe_pkg::TEST_TREE_ENABLE_ADDR;
  endsequence
  a_full_duty_forced: assert property (
    o_full_duty_override |->
      o_fan_duty == {3{thermal_failsafe_pkg::FULL_DUTY}})
    else $error("fan duty not full under override");
  a_loop_duty_pass: assert property (
    !o_full_duty_override && $past(i_reset_n) |->
      o_fan_duty == $past(i_loop_duty))
    else $error("loop duty not passed through");
  a_override_cause: assert property (
    $rose(o_full_duty_override) |->
      $past(new_result, 2) || $past(i_remote1_raw.valid, 3))
    else $error("override rose without a result");
  a_override_release: assert property (
    $fell(o_full_duty_override) |->
      $past(new_result, 2) || $past(i_remote1_raw.valid, 3) ||
      $past(limit_off_wr, 3))
    else $error("override fell without a result");
  a_alarm_dir_gate: assert property (
    o_thermal_alarm_pin_oe |-> $past(i_alarm_pin_is_output))
    else $error("alarm driven while pin is input");
  a_alarm_drive_low: assert property (
    o_thermal_alarm_pin_oe |-> !o_thermal_alarm_pin)
    else $error("alarm pin not driven low");
  a_offset_stage: assert property (
    i_remote1_raw.valid |-> ##2 o_remote1_result.valid)
    else $error("corrected remote result late");
  a_test_tree_set: assert property (
    s_test_on |-> ##[1:2] o_test_tree_on)
    else $error("test tree mode not entered");
  a_lock_holds_test: assert property (
    i_config_lock [*3] |-> $stable(o_test_tree_on))
    else $error("test enable changed while locked");
endmodule

/* dv/thermal_host_model.sv */
module thermal_host_model
(
  input wire logic i_sys_clk,
  input wire logic [7:0] i_reg_rdata,
  output thermal_failsafe_pkg::reg_access_t o_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_reg = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg.write = 1'b1;
    o_reg.addr = a;
    // reserved test enable bits are always written as zero
    o_reg.wdata = (a == thermal_failsafe_pkg::TEST_TREE_ENABLE_ADDR) ?
      (d & 8'h01) : d;
    @(negedge i_sys_clk);
    o_reg.write = 1'b0;
    o_reg.wdata = ~o_reg.wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg.addr = a;
    repeat (2) @(negedge i_sys_clk);
    d = i_reg_rdata;
  endtask
endmodule

/* dv/thermal_failsafe_limit_regs_bench.sv */
module thermal_failsafe_limit_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  thermal_failsafe_pkg::reg_access_t i_reg;
  logic [7:0] o_reg_rdata;
  logic i_config_lock = 1'b0;
  logic i_alarm_pin_is_output = 1'b0;
  thermal_failsafe_pkg::temp_result_t i_remote1_raw = '0;
  thermal_failsafe_pkg::temp_result_t i_local_result = '0;
  thermal_failsafe_pkg::temp_result_t i_remote2_result = '0;
  logic [2:0][7:0] i_fan_start_temperature = {8'h90, 8'h50, 8'h90};
  logic [2:0][7:0] i_loop_duty = {8'h30, 8'h20, 8'h10};
  logic [2:0][7:0] o_fan_duty;
  logic [2:0] o_fan_running;
  logic o_full_duty_override;
  thermal_failsafe_pkg::temp_result_t o_remote1_result;
  logic o_thermal_alarm_pin;
  logic o_thermal_alarm_pin_oe;
  logic o_test_tree_on;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [7:0] rst_v [7] = '{8'hA4, 8'hA4, 8'hA4, 8'h44, 8'h40, 8'h00, 8'h00};
  logic [7:0] new_v [7] = '{8'h9C, 8'h9D, 8'h9E, 8'h65, 8'h75, 8'h01, 8'h06};
  logic [7:0] run_t [4] = '{8'h4B, 8'h51, 8'h4C, 8'h4B};
  logic run_e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  thermal_failsafe_limit_regs thermal_failsafe_limit_regs_i (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata), .i_config_lock(i_config_lock),
    .i_alarm_pin_is_output(i_alarm_pin_is_output),
    .i_remote1_raw(i_remote1_raw), .i_local_result(i_local_result),
    .i_remote2_result(i_remote2_result),
    .i_fan_start_temperature(i_fan_start_temperature),
    .i_loop_duty(i_loop_duty), .o_fan_duty(o_fan_duty),
    .o_fan_running(o_fan_running),
    .o_full_duty_override(o_full_duty_override),
    .o_remote1_result(o_remote1_result), .i_thermal_alarm_pin(1'b1),
    .o_thermal_alarm_pin(o_thermal_alarm_pin),
    .o_thermal_alarm_pin_oe(o_thermal_alarm_pin_oe),
    .o_test_tree_on(o_test_tree_on));
  thermal_host_model thermal_host_model_i (.i_sys_clk(i_sys_clk),
    .i_reg_rdata(o_reg_rdata), .o_reg(i_reg));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp)
      n_mismatch++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    thermal_host_model_i.rd(a, rv);
    check(10'(rv), 10'(exp));
  endtask
  task automatic fan(input logic ovr);
    check(10'(o_full_duty_override), 10'(ovr));
    for (int k = 0; k < 3; k++)
      check(10'(o_fan_duty[k]), ovr ? 10'h0FF : 10'(i_loop_duty[k]));
  endtask
  task automatic temp(input int ch, input logic [9:0] v);
    @(negedge i_sys_clk);
    if (ch == 0)
      i_remote1_raw = {1'b1, v};
    if (ch == 1)
      i_local_result = {1'b1, v};
    if (ch == 2)
      i_remote2_result = {1'b1, v};
    @(negedge i_sys_clk);
    i_remote1_raw.valid = 1'b0;
    i_local_result.valid = 1'b0;
    i_remote2_result.valid = 1'b0;
    repeat (3) @(negedge i_sys_clk);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    for (int i = 0; i < 7; i++)
      rdc(8'(8'h6A + i), rst_v[i]);
    rdc(8'h71, 8'h00);
    for (int i = 0; i < 7; i++)
      thermal_host_model_i.wr(8'(8'h6A + i), new_v[i]);
    for (int i = 0; i < 7; i++)
      rdc(8'(8'h6A + i), new_v[i]);
    check(10'(o_test_tree_on), 10'h001);
    thermal_host_model_i.wr(8'h6F, 8'h00);
    // mode flag follows the stored bit one edge later
    @(negedge i_sys_clk);
    check(10'(o_test_tree_on), 10'h000);
    $display("registers done");
    temp(1, {8'h9E, 2'b00});
    fan(1'b1);
    temp(1, {8'h98, 2'b00});
    fan(1'b1);
    temp(1, {8'h97, 2'b11});
    fan(1'b0);
    i_alarm_pin_is_output = 1'b1;
    temp(1, {8'h9D, 2'b00});
    check(10'(o_thermal_alarm_pin_oe), 10'h000);
    temp(1, {8'h9D, 2'b01});
    check(10'(o_thermal_alarm_pin_oe), 10'h001);
    check(10'(o_thermal_alarm_pin), 10'h000);
    fan(1'b0);
    temp(1, {8'h90, 2'b00});
    check(10'(o_thermal_alarm_pin_oe), 10'h000);
    $display("local limit done");
    temp(2, {8'h9F, 2'b00});
    fan(1'b1);
    thermal_host_model_i.wr(8'h6C, 8'h80);
    temp(2, {8'hF0, 2'b00});
    fan(1'b0);
    check(10'(o_thermal_alarm_pin_oe), 10'h000);
    temp(0, {8'h9C, 2'b00});
    check(o_remote1_result.value, 10'h27C);
    fan(1'b1);
    thermal_host_model_i.wr(8'h70, 8'hF0);
    temp(0, {8'h9C, 2'b00});
    check(o_remote1_result.value, 10'h250);
    fan(1'b0);
    $display("disable and offset done");
    for (int i = 0; i < 4; i++)
    begin
      temp(1, {run_t[i], 2'b00});
      check(10'(o_fan_running[1]), 10'(run_e[i]));
    end
    i_config_lock = 1'b1;
    thermal_host_model_i.wr(8'h6B, 8'h30);
    thermal_host_model_i.wr(8'h6F, 8'h01);
    rdc(8'h6B, 8'h9D);
    check(10'(o_test_tree_on), 10'h000);
    i_config_lock = 1'b0;
    $display("run flag and lock done");
    final_report();
  end
endmodule

bind thermal_failsafe_limit_regs thermal_failsafe_checker checker_i (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg(i_reg),
  .o_reg_rdata(o_reg_rdata), .i_config_lock(i_config_lock),
  .i_alarm_pin_is_output(i_alarm_pin_is_output),
  .i_remote1_raw(i_remote1_raw), .i_local_result(i_local_result),
  .i_remote2_result(i_remote2_result),
  .i_fan_start_temperature(i_fan_start_temperature),
  .i_loop_duty(i_loop_duty), .o_fan_duty(o_fan_duty),
  .o_fan_running(o_fan_running),
  .o_full_duty_override(o_full_duty_override),
  .o_remote1_result(o_remote1_result),
  .i_thermal_alarm_pin(i_thermal_alarm_pin),
  .o_thermal_alarm_pin(o_thermal_alarm_pin),
  .o_thermal_alarm_pin_oe(o_thermal_alarm_pin_oe),
  .o_test_tree_on(o_test_tree_on));
